// *** hdl/epa_pkg.sv ***
package epa_pkg;

  // ---------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------
  localparam int EPA_ADDR_W = 20;
  localparam int EPA_DATA_W = 16;
  localparam int EPA_WORD_W = 24;
  localparam int EPA_NBANK = 4;
  localparam int EPA_NSPACE = 6;
  localparam logic [7:0] EPA_B0_LO_RST = 8'h01;
  localparam logic [7:0] EPA_B1_LO_RST = 8'h40;
  localparam logic [7:0] EPA_B2_LO_RST = 8'h80;
  localparam logic [7:0] EPA_B3_LO_RST = 8'hc0;
  localparam logic [7:0] EPA_B3_HI_RST = 8'hfe;
  localparam logic [7:0] EPA_IO_EXT_FIRST = 8'h20;
  localparam logic [7:0] EPA_BOOT_FIRST = 8'h01;
  localparam logic [7:0] EPA_BOOT_LAST = 8'hfe;
  localparam int EPA_IO_PAGE_W = 10;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int EPA_GRANT_MIN_CYC = 3;
  localparam int EPA_NDMA = 5;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    EPA_SP_BANK0 = 3'h0,
    EPA_SP_BANK1 = 3'h1,
    EPA_SP_BANK2 = 3'h2,
    EPA_SP_BANK3 = 3'h3,
    EPA_SP_IO = 3'h4,
    EPA_SP_BOOT = 3'h5
  } epa_space_t;

  typedef struct packed {
    logic [3:0] rd_wait;
    logic [3:0] wr_wait;
    logic wait_ack_mode;
    logic [2:0] io_clk_div;
    logic wr_hold_ext;
    logic strobe_pol_hi;
    logic bus_16;
  } epa_space_cfg_t;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic is_boot;
    logic write;
    logic pair_rd;
    logic word24;
    logic [23:0] addr;
    logic [23:0] wdata;
  } epa_req_t;

  typedef enum logic [1:0] {
    EPA_ST_OWN = 2'b00,
    EPA_ST_SYNC = 2'b01,
    EPA_ST_GRANT = 2'b11,
    EPA_ST_RECOVER = 2'b10
  } epa_arb_t;

  typedef enum logic [1:0] {
    EPA_XS_IDLE = 2'b00,
    EPA_XS_WAIT = 2'b01,
    EPA_XS_STEP = 2'b11
  } epa_xfer_t;

endpackage : epa_pkg

// *** hdl/epa_ext_port.sv ***
`timescale 1ns/10ps
// Overview of operation
// [RULE_01] Each off-chip space has own access settings
// [RULE_02] External data path is 8 or 16 bits
// [RULE_03] Reset bank page boundaries per bank
// [RULE_04] Bank access asserts its own select
// [RULE_05] I/O pages 0-31 stay on chip
// [RULE_06] I/O pages 32-255 assert I/O select
// [RULE_07] Boot space asserts boot select, core and DMA
// [RULE_08] Outside request granted only when idle
// [RULE_09] Grant at least three cycles after request
// [RULE_10] Release pins, then assert grant; address and control enables drop in the same cycle as grant
// [RULE_11] Off-chip access stalls while granted away
// [RULE_12] No grant between paired reads
// [RULE_13] Grant allowed between read and write
// [RULE_14] Core-exclusive option still grants DMA, outside
// [RULE_15] Request held during use, released ends grant
// [RULE_16] Bus request works during reset; arbiter is held in EPA_ST_OWN during reset, no grant until it ends
// [RULE_17] Grant-hang asserted when access held off
// [RULE_18] DMA requesters in fixed priority order
// [RULE_19] Linked descriptors chain without core
// [RULE_20] DMA steals cycles, not arbitrated vs core
// [RULE_21] 16-bit data, 20-bit address, shared port
// [RULE_22] Word packing for 16/24-bit internal words
// [RULE_23] Pins driven inactive before next access
module epa_ext_port
  import epa_pkg::*;
#(
  parameter int ADDR_W = EPA_ADDR_W,
  parameter int DATA_W = EPA_DATA_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Per-space configuration and bank boundaries
  input wire epa_space_cfg_t [EPA_NSPACE-1:0] space_cfg_i,
  input wire logic [EPA_NBANK-1:0][7:0] bank_lo_i,
  input wire logic bank_lo_load_i,
  input wire logic core_excl_i,
  // Core request
  input wire epa_req_t core_req_i,
  output logic core_ack_o,
  output logic [EPA_WORD_W-1:0] core_rdata_o,
  output logic core_stall_o,
  // DMA requesters
  input wire logic [EPA_NDMA-1:0] dma_req_i,
  input wire logic [EPA_NDMA-1:0] dma_link_i,
  input wire epa_req_t [EPA_NDMA-1:0] dma_xfer_i,
  output logic [EPA_NDMA-1:0] dma_ack_o,
  output logic [EPA_NDMA-1:0] dma_seq_start_o,
  // External pins
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe_o,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic [EPA_NBANK-1:0] bank_select_n_o,
  output logic io_space_select_n_o,
  output logic boot_space_select_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic ctl_oe_o,
  input wire logic ack_i,
  // Outside bus master
  input wire logic ext_bus_request_n_i,
  output logic ext_bus_grant_n_o,
  output logic grant_hang_n_o
);

  initial begin
    if (ADDR_W != EPA_ADDR_W || DATA_W != EPA_DATA_W) begin
      $error("epa_ext_port: port widths fixed at 20-bit address, 16-bit data");
    end
  end

  // ---------------------------------------------------------------
  // Bank boundaries
  // ---------------------------------------------------------------
  logic [EPA_NBANK-1:0][7:0] bank_lo_r;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bank_lo_r <= {EPA_B3_LO_RST, EPA_B2_LO_RST, EPA_B1_LO_RST, EPA_B0_LO_RST}; // RULE_03
    end else if (bank_lo_load_i) begin
      bank_lo_r <= bank_lo_i;
    end
  end

  // ---------------------------------------------------------------
  // Requester selection
  // ---------------------------------------------------------------
  logic [2:0] dma_idx;
  logic dma_any;
  epa_req_t cur_req;
  logic cur_is_dma;

  always_comb begin
    dma_idx = 3'h0;
    dma_any = 1'b0;
    for (int i = EPA_NDMA - 1; i >= 0; i--) begin
      if (dma_req_i[i]) begin
        dma_idx = 3'(i); // RULE_18
        dma_any = 1'b1;
      end
    end
  end

  // DMA steals the port ahead of the core unless core_excl_i is set; core waits, no arbitration
  always_comb begin
    cur_is_dma = dma_any && !core_excl_i; // RULE_20 RULE_14
    cur_req = cur_is_dma ? dma_xfer_i[dma_idx] : core_req_i;
    if (!cur_is_dma && core_excl_i && dma_any && !core_req_i.valid) begin
      cur_is_dma = 1'b1;
      cur_req = dma_xfer_i[dma_idx];
    end
  end

  // ---------------------------------------------------------------
  // Space decode
  // ---------------------------------------------------------------
  epa_space_t cur_space;
  logic cur_offchip;
  logic [7:0] cur_page;

  always_comb begin
    cur_page = cur_req.addr[23:16];
    cur_space = EPA_SP_BANK0;
    cur_offchip = 1'b0;
    if (cur_req.is_io) begin
      cur_space = EPA_SP_IO;
      cur_offchip = cur_req.addr[17:EPA_IO_PAGE_W] >= EPA_IO_EXT_FIRST; // RULE_05 RULE_06
    end else if (cur_req.is_boot) begin
      cur_space = EPA_SP_BOOT;
      cur_offchip = cur_page >= EPA_BOOT_FIRST && cur_page <= EPA_BOOT_LAST; // RULE_07
    end else if (cur_page >= bank_lo_r[0] && cur_page <= EPA_B3_HI_RST) begin
      cur_offchip = 1'b1;
      for (int b = 0; b < EPA_NBANK; b++) begin
        if (cur_page >= bank_lo_r[b]) begin
          cur_space = epa_space_t'(b); // RULE_04
        end
      end
    end
  end

  logic want_port;
  assign want_port = cur_req.valid && cur_offchip;

  // ---------------------------------------------------------------
  // Bus request arbitration
  // ---------------------------------------------------------------
  epa_arb_t arb_r;
  logic [1:0] sync_cnt_r;
  logic xfer_busy;
  logic pair_lock_r;

  // Arbiter held in EPA_ST_OWN during reset: request not granted until reset ends
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      arb_r <= EPA_ST_OWN;
      sync_cnt_r <= 2'h0;
    end else begin
      unique case (arb_r)
        EPA_ST_OWN: begin
          sync_cnt_r <= 2'h0;
          if (!ext_bus_request_n_i) begin
            arb_r <= EPA_ST_SYNC;
          end
        end
        EPA_ST_SYNC: begin
          if (ext_bus_request_n_i) begin
            arb_r <= EPA_ST_OWN;
          end else if (sync_cnt_r < 2'(EPA_GRANT_MIN_CYC - 1)) begin
            sync_cnt_r <= sync_cnt_r + 2'h1; // RULE_09
          end else if (!want_port && !xfer_busy && !pair_lock_r) begin
            arb_r <= EPA_ST_GRANT; // RULE_08 RULE_12 RULE_13
          end
        end
        EPA_ST_GRANT: begin
          if (ext_bus_request_n_i) begin
            arb_r <= EPA_ST_RECOVER; // RULE_15
          end
        end
        EPA_ST_RECOVER: begin
          arb_r <= EPA_ST_OWN; // RULE_23
        end
      endcase
    end
  end

  logic granted;
  assign granted = (arb_r == EPA_ST_GRANT);
  assign ext_bus_grant_n_o = !granted; // RULE_10
  assign ctl_oe_o = !granted; // RULE_10
  assign addr_oe_o = !granted; // RULE_10
  assign core_stall_o = core_req_i.valid && !core_ack_o && (granted || arb_r == EPA_ST_RECOVER); // RULE_11
  assign grant_hang_n_o = !(granted && want_port); // RULE_17

  // ---------------------------------------------------------------
  // Transfer engine
  // ---------------------------------------------------------------
  epa_xfer_t xs_r;
  epa_space_cfg_t cfg_r;
  epa_space_t sp_r;
  epa_req_t req_r;
  logic dma_r;
  logic [2:0] owner_r;
  logic [3:0] wait_r;
  logic [1:0] step_r;
  logic [1:0] nsteps;
  logic [EPA_WORD_W-1:0] asm_r;
  logic can_start;

  assign xfer_busy = (xs_r != EPA_XS_IDLE);
  // Pending outside request is lowest priority: accesses still start while it syncs
  assign can_start = want_port && !xfer_busy
                     && (arb_r == EPA_ST_OWN || arb_r == EPA_ST_SYNC); // RULE_08 RULE_11 RULE_23

  // Index of the last external access for one internal word (accesses minus one)
  always_comb begin
    if (req_r.word24) begin
      nsteps = cfg_r.bus_16 ? 2'd1 : 2'd2; // RULE_22
    end else begin
      nsteps = cfg_r.bus_16 ? 2'd0 : 2'd1; // RULE_02
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xs_r <= EPA_XS_IDLE;
      cfg_r <= '0;
      sp_r <= EPA_SP_BANK0;
      req_r <= '0;
      dma_r <= 1'b0;
      owner_r <= 3'h0;
      wait_r <= 4'h0;
      step_r <= 2'h0;
      asm_r <= '0;
    end else begin
      unique case (xs_r)
        EPA_XS_IDLE: begin
          if (can_start) begin
            xs_r <= EPA_XS_WAIT;
            cfg_r <= space_cfg_i[cur_space]; // RULE_01
            sp_r <= cur_space;
            req_r <= cur_req;
            dma_r <= cur_is_dma;
            owner_r <= dma_idx;
            wait_r <= cur_req.write ? space_cfg_i[cur_space].wr_wait
                                    : space_cfg_i[cur_space].rd_wait;
            step_r <= 2'h0;
            asm_r <= '0;
          end
        end
        EPA_XS_WAIT: begin
          if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
          end else if (!cfg_r.wait_ack_mode || ack_i) begin
            xs_r <= EPA_XS_STEP;
            if (cfg_r.bus_16 && step_r == 2'h0) begin
              asm_r[15:0] <= data_i; // RULE_22
            end else if (cfg_r.bus_16) begin
              asm_r[23:16] <= data_i[7:0]; // RULE_22
            end else begin
              asm_r[8*step_r +: 8] <= data_i[7:0];
            end
          end
        end
        EPA_XS_STEP: begin
          if (step_r == nsteps) begin
            xs_r <= EPA_XS_IDLE;
          end else begin
            xs_r <= EPA_XS_WAIT;
            step_r <= step_r + 2'h1;
            wait_r <= req_r.write ? cfg_r.wr_wait : cfg_r.rd_wait;
          end
        end
      endcase
    end
  end

  // Hold the port between the two reads of a paired-read instruction
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pair_lock_r <= 1'b0;
    end else if (xs_r == EPA_XS_STEP && step_r == nsteps) begin
      pair_lock_r <= !req_r.write && req_r.pair_rd && !dma_r; // RULE_12 RULE_13
    end else if (can_start) begin
      pair_lock_r <= 1'b0;
    end
  end

  logic done;
  assign done = (xs_r == EPA_XS_STEP) && (step_r == nsteps);
  assign core_ack_o = done && !dma_r;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_rdata_o <= '0;
    end else if (done && !dma_r && !req_r.write) begin
      core_rdata_o <= asm_r;
    end
  end

  // DMA completion and descriptor chaining
  genvar g;
  generate
    for (g = 0; g < EPA_NDMA; g++) begin : g_dma
      assign dma_ack_o[g] = done && dma_r && owner_r == 3'(g);
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          dma_seq_start_o[g] <= 1'b0;
        end else begin
          dma_seq_start_o[g] <= dma_ack_o[g] && dma_link_i[g]; // RULE_19
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  logic active;
  logic [23:0] ext_addr;
  logic [4:0] wsh;
  assign active = (xs_r == EPA_XS_WAIT);

  always_comb begin
    ext_addr = req_r.addr + 24'(step_r);
    wsh = cfg_r.bus_16 ? 5'(16 * step_r) : 5'(8 * step_r);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_o <= '0;
      data_o <= '0;
      data_oe_o <= 1'b0;
      bank_select_n_o <= '1;
      io_space_select_n_o <= 1'b1;
      boot_space_select_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
    end else begin
      addr_o <= ext_addr[ADDR_W-1:0]; // RULE_21
      data_o <= 16'(req_r.wdata >> wsh);
      data_oe_o <= active && req_r.write && !granted;
      for (int b = 0; b < EPA_NBANK; b++) begin
        bank_select_n_o[b] <= !(active && sp_r == epa_space_t'(b)); // RULE_04
      end
      io_space_select_n_o <= !(active && sp_r == EPA_SP_IO); // RULE_06
      boot_space_select_n_o <= !(active && sp_r == EPA_SP_BOOT); // RULE_07
      rd_n_o <= !(active && !req_r.write) ^ cfg_r.strobe_pol_hi;
      wr_n_o <= !(active && req_r.write && !(cfg_r.wr_hold_ext && wait_r == 4'h0))
                ^ cfg_r.strobe_pol_hi;
    end
  end

endmodule : epa_ext_port

// *** dv/epa_ext_port_sva.sv ***
`timescale 1ns/10ps
module epa_ext_port_chk
  import epa_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Watched ports
  input wire logic core_ack_o,
  input wire logic core_stall_o,
  input wire logic [EPA_NDMA-1:0] dma_ack_o,
  input wire logic addr_oe_o,
  input wire logic data_oe_o,
  input wire logic ctl_oe_o,
  input wire logic [EPA_NBANK-1:0] bank_select_n_o,
  input wire logic io_space_select_n_o,
  input wire logic boot_space_select_n_o,
  input wire logic ext_bus_request_n_i,
  input wire logic ext_bus_grant_n_o,
  input wire logic grant_hang_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic [5:0] sel_act;
  assign sel_act = ~{boot_space_select_n_o, io_space_select_n_o, bank_select_n_o};
  grant_min_a: assert property ($fell(ext_bus_grant_n_o) |-> !$past(ext_bus_request_n_i, 1)
    && !$past(ext_bus_request_n_i, 2) && !$past(ext_bus_request_n_i, 3))
    else $error("grant came too soon after request");
  pins_float_a: assert property (!ext_bus_grant_n_o |-> !addr_oe_o && !ctl_oe_o && !data_oe_o)
    else $error("pins driven while granted");
  grant_end_a: assert property (ext_bus_request_n_i && !ext_bus_grant_n_o |-> ##[1:2] ext_bus_grant_n_o)
    else $error("grant not released");
  grant_hold_a: assert property (!ext_bus_request_n_i && !ext_bus_grant_n_o |=> !ext_bus_grant_n_o)
    else $error("grant dropped while request held");
  one_select_a: assert property ($onehot0(sel_act))
    else $error("more than one space selected");
  hang_cause_a: assert property (!grant_hang_n_o |-> !ext_bus_grant_n_o)
    else $error("grant hang without grant");
  no_ack_away_a: assert property (!ext_bus_grant_n_o |-> !core_ack_o && (dma_ack_o == '0))
    else $error("access done while granted away");
  ack_single_a: assert property ($onehot0({core_ack_o, dma_ack_o}))
    else $error("two acks at once");
endmodule : epa_ext_port_chk

bind epa_ext_port epa_ext_port_chk epa_ext_port_chk_inst (.clk_i(clk_i), .rstn_i(rstn_i),
  .core_ack_o(core_ack_o), .core_stall_o(core_stall_o), .dma_ack_o(dma_ack_o),
  .addr_oe_o(addr_oe_o), .data_oe_o(data_oe_o), .ctl_oe_o(ctl_oe_o),
  .bank_select_n_o(bank_select_n_o), .io_space_select_n_o(io_space_select_n_o),
  .boot_space_select_n_o(boot_space_select_n_o), .ext_bus_request_n_i(ext_bus_request_n_i),
  .ext_bus_grant_n_o(ext_bus_grant_n_o), .grant_hang_n_o(grant_hang_n_o));

// *** dv/epa_mem_model.sv ***
`timescale 1ns/10ps
module epa_mem_model
  import epa_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Pins from the port
  input wire logic [EPA_ADDR_W-1:0] addr_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic ctl_oe_o,
  // Answer
  output logic [EPA_DATA_W-1:0] data_i,
  output logic ack_i
);
  logic [EPA_DATA_W-1:0] last_r;
  logic [1:0] dly_r;
  logic rd_act;
  logic strobe;
  assign rd_act = ctl_oe_o && !rd_n_o;
  assign strobe = ctl_oe_o && (!rd_n_o || !wr_n_o);
  // Released bus shows the inverse of the last value
  assign data_i = rd_act ? (addr_o[15:0] ^ 16'h5a5a) : ~last_r;
  // Slow device: ready only from the third strobe cycle
  assign ack_i = dly_r[1];
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_r <= '0;
      dly_r <= '0;
    end else begin
      if (rd_act) last_r <= data_i;
      dly_r <= !strobe ? 2'h0 : (dly_r[1] ? dly_r : dly_r + 2'h1);
    end
  end
endmodule : epa_mem_model

// *** dv/tb_epa_ext_port.sv ***
`timescale 1ns/10ps
module tb_epa_ext_port
  import epa_pkg::*;
;
  logic clk_i = 0;
  logic rstn_i = 0;
  logic br_n = 1;
  epa_space_cfg_t [EPA_NSPACE-1:0] cfg;
  logic [EPA_NBANK-1:0][7:0] blo = {8'hc0, 8'h80, 8'h40, 8'h01};
  epa_req_t creq = '0;
  epa_req_t r;
  epa_req_t [EPA_NDMA-1:0] dx = '0;
  logic [EPA_NDMA-1:0] dreq = '0, dack, dstart, pend;
  logic cack, cstall, aoe, doe, coe, rdn, wrn, ackx, gnt_n, hang_n, iosn, bootsn, got;
  logic [23:0] crd;
  logic [19:0] addr;
  logic [15:0] din, dout, lw;
  logic [3:0] bsn;
  logic [5:0] seen;
  logic [7:0] pg;
  logic [1:0] kd;
  logic [9:0] tc [15] = '{10'h001, 10'h03f, 10'h040, 10'h07f, 10'h080, 10'h0bf, 10'h0c0,
    10'h0fe, 10'h000, 10'h0ff, 10'h120, 10'h1ff, 10'h11f, 10'h201, 10'h2fe};
  int n_mismatch = 0, compares = 0, cnt;
  int seed = 32'h41aa48ee;

  epa_ext_port epa_ext_port_inst (.clk_i(clk_i), .rstn_i(rstn_i), .space_cfg_i(cfg),
    .bank_lo_i(blo), .bank_lo_load_i(1'b0), .core_excl_i(1'b0), .core_req_i(creq),
    .core_ack_o(cack), .core_rdata_o(crd), .core_stall_o(cstall), .dma_req_i(dreq),
    .dma_link_i(5'h01), .dma_xfer_i(dx), .dma_ack_o(dack), .dma_seq_start_o(dstart),
    .addr_o(addr), .addr_oe_o(aoe), .data_i(din), .data_o(dout), .data_oe_o(doe),
    .bank_select_n_o(bsn), .io_space_select_n_o(iosn), .boot_space_select_n_o(bootsn),
    .rd_n_o(rdn), .wr_n_o(wrn), .ctl_oe_o(coe), .ack_i(ackx),
    .ext_bus_request_n_i(br_n), .ext_bus_grant_n_o(gnt_n), .grant_hang_n_o(hang_n));
  epa_mem_model epa_mem_model_inst (.clk_i(clk_i), .rstn_i(rstn_i), .addr_o(addr),
    .rd_n_o(rdn), .wr_n_o(wrn), .ctl_oe_o(coe), .data_i(din), .ack_i(ackx));

  // ---------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------
  task chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      n_mismatch++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen_v, exp_v);
    end
  endtask : chk

  task summarize;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  function logic [5:0] dec_exp(input logic [7:0] p, input logic [1:0] k);
    if (k == 2'h1) return (p >= EPA_IO_EXT_FIRST) ? 6'h10 : 6'h00;
    if (k == 2'h2) return (p >= 8'h01 && p <= EPA_BOOT_LAST) ? 6'h20 : 6'h00;
    return (p == 8'h00 || p == 8'hff) ? 6'h00 : 6'h01 << p[7:6];
  endfunction : dec_exp

  function logic [4:0] prio_pick(input logic [4:0] q);
    return q & (~q + 5'h1);
  endfunction : prio_pick

  task core_wait(input int maxc);
    seen = '0;
    got = 0;
    for (int k = 0; k < maxc && !got; k++) begin
      @(negedge clk_i);
      seen |= ~{bootsn, iosn, bsn};
      got = cack;
    end
    @(negedge clk_i);
    seen |= ~{bootsn, iosn, bsn};
    creq.valid = 0;
  endtask : core_wait

  task core_go(input epa_req_t q);
    @(negedge clk_i);
    creq = q;
    core_wait(40);
  endtask : core_go

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial forever #25 clk_i = ~clk_i;
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end
  initial begin
    for (int i = 0; i < EPA_NSPACE; i++) cfg[i] = {4'h1, 4'h2, i == 1, 3'h0, 3'h1};
    repeat (5) @(posedge clk_i);
    chk({bootsn, iosn, bsn, gnt_n}, 7'h7f);
    @(negedge clk_i);
    rstn_i = 1;
    for (int i = 0; i < 40; i++) begin
      kd = (i < 15) ? tc[i][9:8] : 2'({$random(seed)} % 3);
      pg = (i < 15) ? tc[i][7:0] : 8'($random(seed));
      lw = 16'($random(seed));
      r = '0;
      r.valid = 1;
      r.is_io = (kd == 2'h1);
      r.is_boot = (kd == 2'h2);
      r.write = i[0];
      r.wdata = 24'($random(seed));
      r.addr = (kd == 2'h1) ? {6'h00, pg, lw[9:0]} : {pg, lw};
      core_go(r);
      chk(seen, dec_exp(pg, kd));
      chk(got, dec_exp(pg, kd) != 6'h00);
    end
    @(negedge clk_i);
    for (int i = 0; i < EPA_NDMA; i++) dx[i] = {1'b1, 5'h02, 8'h40 + 8'(i), 16'($random(seed)), 24'h0};
    dreq = 5'h1f;
    for (int k = 0; k < 300 && dreq != 0; k++) begin
      @(negedge clk_i);
      if (dack != 0) begin
        chk(dack, prio_pick(dreq));
        pend = dack;
        @(negedge clk_i);
        chk(dstart, pend & 5'h01);
        dreq &= ~pend;
      end
    end
    chk(dreq, 0);
    br_n = 0;
    for (cnt = 0; gnt_n !== 1'b0 && cnt < 20; cnt++) @(negedge clk_i);
    chk(cnt >= EPA_GRANT_MIN_CYC && cnt < 20, 1);
    chk({aoe, coe, doe}, 3'h0);
    creq = '0;
    creq.valid = 1;
    creq.addr = 24'h400010;
    repeat (4) @(negedge clk_i);
    chk({cstall, hang_n, cack}, 3'b100);
    br_n = 1;
    repeat (2) @(negedge clk_i);
    chk(gnt_n, 1);
    core_wait(40);
    chk({got, seen}, 7'h42);
    r = '0;
    r.valid = 1;
    r.pair_rd = 1;
    r.addr = 24'h010020;
    core_go(r);
    br_n = 0;
    repeat (6) @(negedge clk_i);
    chk(gnt_n, 1);
    r.pair_rd = 0;
    core_go(r);
    chk(got, 1);
    repeat (6) @(negedge clk_i);
    chk(gnt_n, 0);
    br_n = 1;
    repeat (4) @(negedge clk_i);
    chk(gnt_n, 1);
    summarize();
  end
endmodule : tb_epa_ext_port
